// ===== wdt_apb_master.sv
module wdt_apb_master
(
    input  logic                  clk,
    output wdt_pkg::wdt_apb_req_s apb_req,
    input  logic [31:0]           prdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;
    initial apb_req = '0;
    // released lines show inverted values, never the last ones
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rv);
        @(posedge clk);
        #1 apb_req = '{1'b1, 1'b0, w, a[11:2], d};
        @(posedge clk);
        #1 apb_req.penable = 1'b1;
        @(posedge clk);
        rv = prdata;
        #1 apb_req = '{1'b0, 1'b0, ~w, ~a[11:2], ~d};
    endtask
endmodule

// ===== wdt_assertions.sv
`include "wdt_cfg.svh"

module wdt_assertions
(
    input logic                  clk,
    input logic                  rst_n,
    input logic                  count_domain_reset_n,
    input logic                  count_clock_enable,
    input wdt_pkg::wdt_apb_req_s apb_req,
    input logic [31:0]           prdata,
    input logic                  timeout_irq_out,
    input logic                  timeout_reset_out
);
    import wdt_pkg::*;
    logic rd;
    logic wr;
    logic lock_seen_q;
    assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    // a clear while locked is refused, so follow the lock from bus writes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lock_seen_q <= 1'b0;
        else if (wr && apb_req.paddr == 10'h300)
            lock_seen_q <= (apb_req.pwdata != `WDT_LOCK_KEY);
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // no count edge, so a same-cycle timeout cannot mask the clear
    a_clear_drops_irq:
        assert property (wr && apb_req.paddr == 10'h003 && !lock_seen_q && !count_clock_enable |=> !timeout_irq_out)
        else $error("irq held after clear");
    a_reset_after_irq:
        assert property ($rose(timeout_reset_out) |-> $past(timeout_irq_out))
        else $error("reset without pending irq");
    a_count_rst_clears:
        assert property (!count_domain_reset_n |=> !timeout_irq_out && !timeout_reset_out)
        else $error("outputs high after count reset");
    a_lock_read_flag:
        assert property (rd && apb_req.paddr == 10'h300 |=> prdata[31:1] == 31'h0)
        else $error("lock read not a flag");
    a_ctl_reserved_zero:
        assert property (rd && apb_req.paddr == 10'h002 |=> prdata[31:2] == 30'h0)
        else $error("control reserved bits set");
    a_status_one_bit:
        assert property (rd && apb_req.paddr[11:3] == 9'h002 |=> prdata[31:1] == 31'h0)
        else $error("status reserved bits set");
    a_unmapped_zero:
        assert property (rd && apb_req.paddr == 10'h006 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_prdata_holds:
        assert property (!rd |=> $stable(prdata))
        else $error("read data moved");
endmodule
bind wdt_top wdt_assertions u_chk (.clk(clk), .rst_n(rst_n), .count_domain_reset_n(count_domain_reset_n),
    .count_clock_enable(count_clock_enable), .apb_req(apb_req), .prdata(prdata),
    .timeout_irq_out(timeout_irq_out), .timeout_reset_out(timeout_reset_out));

// ===== wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
// Summary of operation
// - 32-bit reload value; any write restarts the countdown from the new value.
// - reload of 1 is the least useful; reload 0 raises the interrupt at once.
// - read-only 32-bit register returns the live down-counter value.
// - control bit 1 gates the timeout reset output; low masks it.
// - control bit 0 high runs counter and interrupt; low stops and disables both.
// - control bit 0 rising loads the counter from the reload value.
// - any write to interrupt clear clears the interrupt and reloads the counter; a timeout in the same cycle keeps the interrupt set.
// - raw status bit 0 shows a counter timeout regardless of enable.
// - masked status bit 0 is raw AND control bit 0, also drives the irq pin.
// - writing the key to the lock register unlocks writes to all registers.
// - any other value locks other registers; the lock register stays writable.
// - lock register reads 0 when unlocked, 1 when locked.
// - accesses decode word address bits 11:2 with 32-bit write and read data.
// - interrupt output is active high.
// - timeout reset output is active high.
// - active-low count-domain reset clears the counter-domain state.
// - counter decrements only on clock edges with the count enable high.
// - at zero raise the interrupt, reload, and count again.
// - second zero with interrupt pending and reset enabled asserts reset and stops.
// - a clear write without a timeout in the same cycle drops the interrupt output at once.

`define WDT_OFF_RELOAD      12'h000
`define WDT_OFF_COUNT       12'h004
`define WDT_OFF_CONTROL     12'h008
`define WDT_OFF_INTCLR      12'h00c
`define WDT_OFF_RAW         12'h010
`define WDT_OFF_MASKED      12'h014
`define WDT_OFF_LOCK        12'hc00

`define WDT_RELOAD_RST      32'hffffffff
`define WDT_COUNT_RST       32'hffffffff
`define WDT_LOCK_KEY        32'h1acce551
`define WDT_LOCK_LOCKED     32'h00000001
`define WDT_LOCK_OPEN       32'h00000000

`define WDT_CTL_IRQ_EN_BIT  0
`define WDT_CTL_RST_EN_BIT  1
`define WDT_RAW_BIT         0
`define WDT_MASKED_BIT      0
`endif

// ===== wdt_pkg.sv
package wdt_pkg;
    typedef struct packed
    {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:2] paddr;
        logic [31:0] pwdata;
    } wdt_apb_req_s;

    typedef enum
    {
        WDT_SEL_NONE,
        WDT_SEL_RELOAD,
        WDT_SEL_COUNT,
        WDT_SEL_CONTROL,
        WDT_SEL_INTCLR,
        WDT_SEL_RAW,
        WDT_SEL_MASKED,
        WDT_SEL_LOCK
    } wdt_sel_e;
endpackage

// ===== wdt_top.sv
`include "wdt_cfg.svh"

module wdt_top
(
    input  logic                  clk,
    input  logic                  rst_n,
    input  logic                  count_domain_reset_n,
    input  logic                  count_clock_enable,
    input  wdt_pkg::wdt_apb_req_s apb_req,
    output logic [31:0]           prdata,
    output logic                  timeout_irq_out,
    output logic                  timeout_reset_out
);
    import wdt_pkg::*;

    function automatic wdt_sel_e wdt_decode(input logic [11:2] addr);
        logic [11:0] byte_addr;
        byte_addr = {addr, 2'b00};
        case (byte_addr)
            `WDT_OFF_RELOAD:  wdt_decode = WDT_SEL_RELOAD;
            `WDT_OFF_COUNT:   wdt_decode = WDT_SEL_COUNT;
            `WDT_OFF_CONTROL: wdt_decode = WDT_SEL_CONTROL;
            `WDT_OFF_INTCLR:  wdt_decode = WDT_SEL_INTCLR;
            `WDT_OFF_RAW:     wdt_decode = WDT_SEL_RAW;
            `WDT_OFF_MASKED:  wdt_decode = WDT_SEL_MASKED;
            `WDT_OFF_LOCK:    wdt_decode = WDT_SEL_LOCK;
            default:          wdt_decode = WDT_SEL_NONE;
        endcase
    endfunction

    // control bit as it stands after this edge, so outputs follow a write without lag
    function automatic logic wdt_ctl_next(input logic wr, input logic new_bit, input logic cur);
        if (wr)
        begin
            wdt_ctl_next = new_bit;
        end
        else
        begin
            wdt_ctl_next = cur;
        end
    endfunction

    function automatic logic wdt_masked(input logic raw, input logic en);
        wdt_masked = raw & en;
    endfunction

    function automatic logic [31:0] wdt_flag_word(input logic flag);
        wdt_flag_word = {31'h00000000, flag};
    endfunction

    logic [31:0] reload_q;
    logic [31:0] count_q;
    logic        irq_en_q;
    logic        rst_en_q;
    logic        locked_q;
    logic        raw_q;
    logic        raw_d;
    logic        load_pend_q;
    logic        stopped_q;
    logic [31:0] prdata_q;
    logic        irq_q;
    logic        reset_out_q;

    wdt_sel_e    sel;
    logic        wr_access;
    logic        rd_setup;
    logic        wr_open;
    logic        wr_reload;
    logic        wr_control;
    logic        wr_intclr;
    logic        tick;
    logic        at_zero;
    logic        timeout;
    logic        wr_lock;
    logic        irq_en_d;
    logic        rst_en_d;
    logic        second_timeout;
    logic [31:0] prdata_d;

    // apb: setup phase psel without penable, access phase with penable
    assign sel        = wdt_decode(apb_req.paddr);
    assign wr_access  = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_setup   = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign wr_open    = wr_access & ~locked_q;
    assign wr_reload  = wr_open & (sel == WDT_SEL_RELOAD);
    assign wr_control = wr_open & (sel == WDT_SEL_CONTROL);
    assign wr_intclr  = wr_open & (sel == WDT_SEL_INTCLR);
    assign wr_lock    = wr_access & (sel == WDT_SEL_LOCK);

    // counting pauses entirely once the reset has fired
    assign tick    = count_clock_enable & irq_en_q & ~stopped_q;
    assign at_zero = (count_q == 32'h00000000);
    assign timeout = tick & ~load_pend_q & at_zero;

    // enables after this edge; irq and reset outputs track a control write at once
    assign irq_en_d       = wdt_ctl_next(wr_control, apb_req.pwdata[`WDT_CTL_IRQ_EN_BIT], irq_en_q);
    assign rst_en_d       = wdt_ctl_next(wr_control, apb_req.pwdata[`WDT_CTL_RST_EN_BIT], rst_en_q);
    assign second_timeout = timeout & raw_q & rst_en_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            locked_q <= 1'b0;
        end
        else if (wr_lock)
        begin
            locked_q <= (apb_req.pwdata != `WDT_LOCK_KEY);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reload_q <= `WDT_RELOAD_RST;
        end
        else if (wr_reload)
        begin
            reload_q <= apb_req.pwdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_en_q <= 1'b0;
        end
        else if (wr_control)
        begin
            // upper bits are dropped on purpose
            irq_en_q <= apb_req.pwdata[`WDT_CTL_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rst_en_q <= 1'b0;
        end
        else if (wr_control)
        begin
            rst_en_q <= apb_req.pwdata[`WDT_CTL_RST_EN_BIT];
        end
    end

    // load waits for the next enabled count edge after enable rises
    always_ff @(posedge clk)
    begin
        if (!count_domain_reset_n)
        begin
            load_pend_q <= 1'b0;
        end
        else if (wr_control && apb_req.pwdata[`WDT_CTL_IRQ_EN_BIT] && !irq_en_q)
        begin
            load_pend_q <= 1'b1;
        end
        else if (tick || wr_reload || wr_intclr)
        begin
            load_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!count_domain_reset_n)
        begin
            count_q <= `WDT_COUNT_RST;
        end
        else if (wr_reload)
        begin
            count_q <= apb_req.pwdata;
        end
        else if (wr_intclr)
        begin
            count_q <= reload_q;
        end
        else if (tick)
        begin
            if (load_pend_q)
            begin
                count_q <= reload_q;
            end
            else if (at_zero)
            begin
                count_q <= reload_q;
            end
            else
            begin
                count_q <= count_q - 32'h00000001;
            end
        end
    end

    // a timeout in the same cycle as a clear keeps the flag set
    always_comb
    begin
        raw_d = raw_q;
        if (wr_intclr)
        begin
            raw_d = 1'b0;
        end
        if (timeout)
        begin
            raw_d = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!count_domain_reset_n)
        begin
            raw_q <= 1'b0;
        end
        else
        begin
            raw_q <= raw_d;
        end
    end

    // only a fresh watchdog reset restarts a stopped counter
    always_ff @(posedge clk)
    begin
        if (!count_domain_reset_n)
        begin
            stopped_q <= 1'b0;
        end
        else if (second_timeout)
        begin
            stopped_q <= 1'b1;
        end
    end

    // irq follows next-state values so a clear drops it without delay
    always_ff @(posedge clk)
    begin
        if (!count_domain_reset_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= wdt_masked(raw_d, irq_en_d);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!count_domain_reset_n)
        begin
            reset_out_q <= 1'b0;
        end
        else
        begin
            reset_out_q <= (second_timeout || stopped_q) && rst_en_d;
        end
    end

    // read word picked from the live registers; write-only and unmapped read zero
    always_comb
    begin
        prdata_d = 32'h00000000;
        case (sel)
            WDT_SEL_RELOAD:  prdata_d = reload_q;
            WDT_SEL_COUNT:   prdata_d = count_q;
            WDT_SEL_CONTROL: prdata_d = {30'h00000000, rst_en_q, irq_en_q};
            WDT_SEL_RAW:     prdata_d = wdt_flag_word(raw_q);
            WDT_SEL_MASKED:  prdata_d = wdt_flag_word(wdt_masked(raw_q, irq_en_q));
            WDT_SEL_LOCK:    prdata_d = locked_q ? `WDT_LOCK_LOCKED : `WDT_LOCK_OPEN;
            default:         prdata_d = 32'h00000000;
        endcase
    end

    // read data latched in setup phase, stable through access phase
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prdata_q <= 32'h00000000;
        end
        else if (rd_setup)
        begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata            = prdata_q;
    assign timeout_irq_out   = irq_q;
    assign timeout_reset_out = reset_out_q;
endmodule

// ===== wdt_top_tb_top.sv
module wdt_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;
    logic         clk = 1'b0, rst_n = 1'b0, cdr_n = 1'b0, ce = 1'b0, irq, rso;
    logic [31:0]  prdata, r, r1;
    wdt_apb_req_s apb_req;
    int           n_errors = 0, total_checks = 0, cyc = 0;
    always #10 clk = ~clk;
    wdt_top dut (.clk(clk), .rst_n(rst_n), .count_domain_reset_n(cdr_n), .count_clock_enable(ce),
        .apb_req(apb_req), .prdata(prdata), .timeout_irq_out(irq), .timeout_reset_out(rso));
    wdt_apb_master bus (.clk(clk), .apb_req(apb_req), .prdata(prdata));
    task results;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        bus.xfer(1'b1, a, d, r);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        bus.xfer(1'b0, a, 32'h0, r);
        ck(r, e);
    endtask
    task step(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task t_reset;
        rd(12'h000, 32'hffffffff);
        rd(12'h004, 32'hffffffff);
        rd(12'h008, 32'h0);
        rd(12'hc00, 32'h0);
        rd(12'h018, 32'h0);
        $display("t_reset done");
    endtask
    task t_lock;
        wr(12'hc00, 32'h1acce550);
        rd(12'hc00, 32'h1);
        wr(12'h000, 32'h5);
        rd(12'h000, 32'hffffffff);
        wr(12'hc00, 32'h1acce551);
        rd(12'hc00, 32'h0);
        wr(12'h004, 32'h0);
        rd(12'h004, 32'hffffffff);
        wr(12'h008, 32'hfffffffe);
        rd(12'h008, 32'h2);
        $display("t_lock done");
    endtask
    task t_irq;
        wr(12'h000, 32'h4);
        ce = 1'b1;
        wr(12'h008, 32'h1);
        for (int i = 0; i < 30 && irq !== 1'b1; i++)
            step(1);
        ck(irq, 1'b1);
        rd(12'h010, 32'h1);
        rd(12'h014, 32'h1);
        ce = 1'b0;
        wr(12'h00c, 32'h0);
        ck(irq, 1'b0);
        rd(12'h010, 32'h0);
        rd(12'h004, 32'h4);
        wr(12'h000, 32'h9);
        rd(12'h004, 32'h9);
        ce = 1'b1;
        wr(12'h008, 32'h0);
        bus.xfer(1'b0, 12'h004, 32'h0, r1);
        ck(r1, 32'h6);
        repeat (4) @(posedge clk);
        rd(12'h004, r1);
        ce = 1'b0;
        wr(12'h008, 32'h1);
        @(posedge clk);
        #1 ce = 1'b1;
        @(posedge clk);
        #1 ce = 1'b0;
        rd(12'h004, 32'h9);
        wr(12'h000, 32'h0);
        ce = 1'b1;
        for (int i = 0; i < 10 && irq !== 1'b1; i++)
            step(1);
        ck(irq, 1'b1);
        ce = 1'b0;
        wr(12'h008, 32'h0);
        step(1);
        ck(irq, 1'b0);
        rd(12'h010, 32'h1);
        rd(12'h014, 32'h0);
        $display("t_irq done");
    endtask
    task t_rst;
        wr(12'h00c, 32'h0);
        wr(12'h000, 32'h3);
        wr(12'h008, 32'h3);
        ce = 1'b1;
        for (int i = 0; i < 40 && rso !== 1'b1; i++)
            step(1);
        ck(rso, 1'b1);
        ck(irq, 1'b1);
        bus.xfer(1'b0, 12'h004, 32'h0, r1);
        rd(12'h004, r1);
        wr(12'h008, 32'h1);
        step(1);
        ck(rso, 1'b0);
        ce = 1'b0;
        @(posedge clk);
        #1 cdr_n = 1'b0;
        @(posedge clk);
        #1 cdr_n = 1'b1;
        ck(irq, 1'b0);
        rd(12'h004, 32'hffffffff);
        $display("t_rst done");
    endtask
    // hang guard, well above the fewer than 200 cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            results;
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        cdr_n = 1'b1;
        t_reset;
        t_lock;
        t_irq;
        t_rst;
        results;
    end
endmodule
